// ### src/pig_pkg.sv
// constants for the pin interrupt and ganged output block
package pig_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_GANG = 8'h00;
    localparam logic [7:0] ADDR_PWR = 8'h04;
    localparam logic [7:0] ADDR_PORT_BASE = 8'h10;
    localparam logic [7:0] ADDR_PORT_STRIDE = 8'h10;
    localparam logic [7:0] OFF_SC = 8'h00;
    localparam logic [7:0] OFF_PS = 8'h04;
    localparam logic [7:0] OFF_ES = 8'h08;
    localparam logic [7:0] OFF_PE = 8'h0c;
    // ganged_output_control fields
    localparam int GANG_EN_BIT = 0;
    // pin_irq_status_control fields
    localparam int SC_MOD_BIT = 0;
    localparam int SC_IE_BIT = 1;
    localparam int SC_ACK_BIT = 2;
    localparam int SC_FLAG_BIT = 3;
    // power_mgmt_status_control2 fields
    localparam int PWR_PARTIAL_POWERDOWN_CONTROL_BIT = 0;
    localparam int PWR_ACK_BIT = 2;
    localparam int PWR_FLAG_BIT = 3;
    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    // ganged pin order: 0=port C0, 1..3=port C1..C3, 4..7=port B2..B5
    localparam int GANG_PINS = 8;
    localparam int IRQ_PORTS = 2;
endpackage

// ### src/pig_pin_ctrl.sv
// pin interrupt detection, ganged output drive and stop retention
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
// Function
// - ganged control register takes one write: enable plus seven pin selects
// - select bits 7..1 map to B5,B4,B3,B2,C3,C2,C1
// - ganged pins become outputs copying C0 data, drive, slew
// - ganging enabled forces C0 output regardless of its direction bit
// - ganging beats digital peripherals; enabled analog beats ganging
// - low four bits of ports A and B are interrupt and wake inputs
// - per-pin enable bit switches each pin's detection on or off
// - per-port mode bit picks edge-only or edge-and-level
// - per-pin edge select picks falling/low or rising/high
// - inputs sampled every bus cycle; edge is change between cycles
// - edge counts only after pin seen at deasserted level
// - edge sets port flag; flag with enable requests interrupt
// - writing one to acknowledge clears the flag
// - edge-and-level mode: edge or asserted level sets flag
// - edge-and-level acknowledge clears only when all enabled inputs deasserted
// - with pull enabled, edge select zero pulls up, one pulls down
// - stop2 keeps pin output latches as before stop entry
// - stop3 keeps all state; pins usable at once on recovery
// - powerdown flag read-only, set on stop2 recovery, cleared by ack write
// - powerdown control written once after reset: zero stop3, one stop2
module pig_pin_ctrl #(
    parameter int IRQ_PINS = 4
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_port_c_bit0_data,
    input wire logic i_port_c_bit0_drive_select,
    input wire logic i_port_c_bit0_slew_enable,
    input wire logic i_port_c_bit0_direction,
    input wire logic [7:0] i_analog_enable,
    input wire logic i_stop2_hold,
    input wire logic i_stop2_recovered,
    input wire logic [2*IRQ_PINS-1:0] i_irq_pin,
    output logic [7:0] o_gang_active,
    output logic [7:0] o_gang_oe,
    output logic [7:0] o_gang_data,
    output logic [7:0] o_gang_drive,
    output logic [7:0] o_gang_slew,
    output logic [2*IRQ_PINS-1:0] o_pull_enable,
    output logic [2*IRQ_PINS-1:0] o_pull_down,
    output logic o_stop2_select,
    output logic [1:0] o_port_irq,
    output logic o_irq
);
    localparam int NP = 2 * IRQ_PINS;

    // register fields are one byte wide, so a port can serve at most eight pins
    generate
        if (IRQ_PINS < 1 || IRQ_PINS > 8) begin : g_bad_pins
            $error("IRQ_PINS must be 1 to 8");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // bus decode
    logic setup;
    logic wr;
    logic [31:0] wdata;
    logic hit_gang;
    logic hit_pwr;
    logic [1:0] hit_sc;
    logic [1:0] hit_ps;
    logic [1:0] hit_es;
    logic [1:0] hit_pe;
    logic mapped;

    assign setup = i_psel && !i_penable;
    assign wr = i_psel && i_penable && i_pwrite;
    assign wdata = i_pwdata;
    assign hit_gang = i_paddr == pig_pkg::ADDR_GANG;
    assign hit_pwr = i_paddr == pig_pkg::ADDR_PWR;

    genvar p;
    generate
        for (p = 0; p < 2; p++) begin : g_dec
            localparam logic [7:0] BASE = 8'(pig_pkg::ADDR_PORT_BASE
                + 8'(p) * pig_pkg::ADDR_PORT_STRIDE);
            assign hit_sc[p] = i_paddr == 8'(BASE + pig_pkg::OFF_SC);
            assign hit_ps[p] = i_paddr == 8'(BASE + pig_pkg::OFF_PS);
            assign hit_es[p] = i_paddr == 8'(BASE + pig_pkg::OFF_ES);
            assign hit_pe[p] = i_paddr == 8'(BASE + pig_pkg::OFF_PE);
        end
    endgenerate

    // unmapped addresses raise pslverr and change no state
    assign mapped = hit_gang || hit_pwr || (|hit_sc) || (|hit_ps) || (|hit_es) || (|hit_pe);
    // no wait states: every access completes in its first access cycle
    assign o_pready = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // ganged output control, write once
    logic gang_en;
    logic [7:1] gang_sel;
    logic gang_locked;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            gang_en <= 1'b0;
            gang_sel <= 7'h00;
            gang_locked <= 1'b0;
        end else if (wr && hit_gang && !gang_locked) begin
            gang_en <= wdata[pig_pkg::GANG_EN_BIT];
            gang_sel <= wdata[7:1];
            gang_locked <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // power management bits
    logic partial_powerdown_control;
    logic partial_powerdown_control_locked;
    logic partial_powerdown_flag;
    logic ppd_ack;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            partial_powerdown_control <= 1'b0;
            partial_powerdown_control_locked <= 1'b0;
        end else if (wr && hit_pwr && !partial_powerdown_control_locked) begin
            partial_powerdown_control <= wdata[pig_pkg::PWR_PARTIAL_POWERDOWN_CONTROL_BIT];
            partial_powerdown_control_locked <= 1'b1;
        end
    end

    assign ppd_ack = wr && hit_pwr && wdata[pig_pkg::PWR_ACK_BIT];

    // recovery wins over a same-cycle acknowledge
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            partial_powerdown_flag <= 1'b0;
        end else if (i_stop2_recovered) begin
            partial_powerdown_flag <= 1'b1;
        end else if (ppd_ack) begin
            partial_powerdown_flag <= 1'b0;
        end
    end

    assign o_stop2_select = partial_powerdown_control;

    ////////////////////////////////////////////////////////////////////////////
    // ganged pin drive
    logic [7:0] gang_want;

    // pin 0 is port C0 itself, forced to output by the enable alone
    assign gang_want = gang_en ? {gang_sel, 1'b1} : 8'h00;

    // flops hold during stop2 so pins keep their pre-stop levels
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_gang_active <= pig_pkg::RST_BYTE;
            o_gang_oe <= pig_pkg::RST_BYTE;
            o_gang_data <= pig_pkg::RST_BYTE;
            o_gang_drive <= pig_pkg::RST_BYTE;
            o_gang_slew <= pig_pkg::RST_BYTE;
        end else if (!i_stop2_hold) begin
            o_gang_active <= gang_want & ~i_analog_enable;
            o_gang_oe <= gang_want & ~i_analog_enable;
            o_gang_data <= gang_want & {8{i_port_c_bit0_data}};
            o_gang_drive <= gang_want & {8{i_port_c_bit0_drive_select}};
            o_gang_slew <= gang_want & {8{i_port_c_bit0_slew_enable}};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin interrupt ports
    logic [1:0] mode;
    logic [1:0] ie;
    logic [1:0] flag;
    logic [NP-1:0] pin_en;
    logic [NP-1:0] edge_sel;
    logic [NP-1:0] pull_en;
    logic [NP-1:0] asserted;
    logic [NP-1:0] prev_deasserted;
    logic [NP-1:0] pin_edge;
    logic [1:0] any_edge;
    logic [1:0] any_level;
    logic [1:0] ack;

    // polarity: select zero makes a low pin asserted
    assign asserted = ~(i_irq_pin ^ edge_sel);
    assign pin_edge = pin_en & prev_deasserted & asserted;

    // last sample deasserted; a disabled pin forgets its history
    // a pin that is already asserted when enabled must go idle before its edge can trip
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prev_deasserted <= '0;
        end else begin
            prev_deasserted <= pin_en & ~asserted;
        end
    end

    generate
        for (p = 0; p < 2; p++) begin : g_port
            localparam int LO = p * IRQ_PINS;
            assign any_edge[p] = |pin_edge[LO +: IRQ_PINS];
            assign any_level[p] = |(pin_en[LO +: IRQ_PINS] & asserted[LO +: IRQ_PINS]);
            assign ack[p] = wr && hit_sc[p] && wdata[pig_pkg::SC_ACK_BIT];

            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    mode[p] <= 1'b0;
                    ie[p] <= 1'b0;
                end else if (wr && hit_sc[p]) begin
                    mode[p] <= wdata[pig_pkg::SC_MOD_BIT];
                    ie[p] <= wdata[pig_pkg::SC_IE_BIT];
                end
            end

            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    pin_en[LO +: IRQ_PINS] <= '0;
                    edge_sel[LO +: IRQ_PINS] <= '0;
                    pull_en[LO +: IRQ_PINS] <= '0;
                end else begin
                    if (wr && hit_ps[p]) begin
                        pin_en[LO +: IRQ_PINS] <= wdata[IRQ_PINS-1:0];
                    end
                    if (wr && hit_es[p]) begin
                        edge_sel[LO +: IRQ_PINS] <= wdata[IRQ_PINS-1:0];
                    end
                    if (wr && hit_pe[p]) begin
                        pull_en[LO +: IRQ_PINS] <= wdata[IRQ_PINS-1:0];
                    end
                end
            end

            // set beats acknowledge; level mode also blocks the clear
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    flag[p] <= 1'b0;
                end else if (any_edge[p] || (mode[p] && any_level[p])) begin
                    flag[p] <= 1'b1;
                end else if (ack[p]) begin
                    flag[p] <= 1'b0;
                end
            end
        end
    endgenerate

    // pull direction follows polarity so the idle level is deasserted
    assign o_pull_enable = pull_en;
    assign o_pull_down = pull_en & edge_sel;
    // requests stay live in stop3 and wait, which is what wakes the core
    assign o_port_irq = flag & ie;
    assign o_irq = |o_port_irq;

    ////////////////////////////////////////////////////////////////////////////
    // read data, captured in the setup cycle
    logic [31:0] next_rdata;

    always_comb begin
        next_rdata = pig_pkg::RST_WORD;
        if (hit_gang) begin
            next_rdata[7:0] = {gang_sel, gang_en};
        end
        if (hit_pwr) begin
            next_rdata[pig_pkg::PWR_FLAG_BIT] = partial_powerdown_flag;
            next_rdata[pig_pkg::PWR_PARTIAL_POWERDOWN_CONTROL_BIT] = partial_powerdown_control;
        end
        for (int k = 0; k < 2; k++) begin
            if (hit_sc[k]) begin
                next_rdata[pig_pkg::SC_FLAG_BIT] = flag[k];
                next_rdata[pig_pkg::SC_IE_BIT] = ie[k];
                next_rdata[pig_pkg::SC_MOD_BIT] = mode[k];
            end
            if (hit_ps[k]) begin
                next_rdata[IRQ_PINS-1:0] = pin_en[k*IRQ_PINS +: IRQ_PINS];
            end
            if (hit_es[k]) begin
                next_rdata[IRQ_PINS-1:0] = edge_sel[k*IRQ_PINS +: IRQ_PINS];
            end
            if (hit_pe[k]) begin
                next_rdata[IRQ_PINS-1:0] = pull_en[k*IRQ_PINS +: IRQ_PINS];
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_prdata <= pig_pkg::RST_WORD;
            o_pslverr <= 1'b0;
        end else if (setup) begin
            // a write returns zero read data, so stale data never looks like an answer
            o_prdata <= i_pwrite ? pig_pkg::RST_WORD : next_rdata;
            o_pslverr <= !mapped;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    chk_gang_once: assert property (
        gang_locked && wr && hit_gang |=> $stable(gang_en) && $stable(gang_sel))
        else $error("ganged control changed after first write");
    chk_c0_forced: assert property (
        gang_en && !i_analog_enable[0] && !i_stop2_hold |=> o_gang_oe[0])
        else $error("port C0 not forced to output");
    chk_gang_follow: assert property (
        gang_en && gang_sel[7] && !i_stop2_hold
        |=> o_gang_data[7] == $past(i_port_c_bit0_data))
        else $error("ganged pin did not follow C0 data");
    chk_analog_wins: assert property (
        i_analog_enable[4] && !i_stop2_hold |=> !o_gang_oe[4] && !o_gang_active[4])
        else $error("analog function did not override gang");
    chk_stop2_hold: assert property (
        i_stop2_hold |=> $stable(o_gang_oe) && $stable(o_gang_data))
        else $error("pin latches moved during stop2");
    chk_edge_sets: assert property (
        pin_en[0] && !edge_sel[0] && !i_irq_pin[0] && $past(i_irq_pin[0])
        && $past(pin_en[0]) && !$past(edge_sel[0]) |=> flag[0])
        else $error("falling edge missed");
    chk_no_arm: assert property (
        !mode[0] && !flag[0] && !(|prev_deasserted[IRQ_PINS-1:0]) |=> !flag[0])
        else $error("flag set without prior deasserted level");
    chk_ack_clears: assert property (
        flag[1] && ack[1] && !any_edge[1] && !mode[1] |=> !flag[1])
        else $error("acknowledge did not clear edge flag");
    chk_level_holds: assert property (
        mode[1] && any_level[1] ##0 ack[1] |=> flag[1])
        else $error("flag cleared while level asserted");
    chk_irq_out: assert property (
        flag[0] && ie[0] |-> o_irq ##0 o_port_irq[0])
        else $error("flag with enable gave no request");
    chk_pull_dir: assert property (
        pull_en[2] |-> o_pull_down[2] == edge_sel[2])
        else $error("pull direction wrong");
    chk_partial_powerdown_control_once: assert property (
        partial_powerdown_control_locked |=> $stable(partial_powerdown_control))
        else $error("powerdown control changed twice");
    chk_partial_powerdown_flag_clear: assert property (
        ppd_ack && !i_stop2_recovered |=> !partial_powerdown_flag)
        else $error("powerdown flag not cleared");

    // drive, release, level set, masking and recovery
    chk_gang_drive: assert property (
        gang_en && gang_sel[4] && !i_stop2_hold |=> o_gang_drive[4] == $past(i_port_c_bit0_drive_select)
        && o_gang_slew[4] == $past(i_port_c_bit0_slew_enable))
        else $error("ganged pin did not follow C0 drive or slew");
    chk_gang_off: assert property (
        !gang_en && !i_stop2_hold |=> o_gang_oe == '0)
        else $error("pin driven while ganging disabled");
    chk_level_sets: assert property (
        mode[1] && any_level[1] |=> flag[1])
        else $error("asserted level did not set flag");
    chk_irq_masked: assert property (
        !ie[0] |-> !o_port_irq[0])
        else $error("request raised while masked");
    chk_partial_powerdown_flag_sets: assert property (
        i_stop2_recovered |=> partial_powerdown_flag)
        else $error("powerdown flag not set on recovery");

    cov_edge_irq: cover property (!flag[0] ##1 flag[0] && ie[0] ##[1:20] ack[0]);
    cov_level_blocked: cover property (mode[1] && any_level[1] && ack[1]);
    cov_gang_on: cover property ($rose(gang_en) ##1 o_gang_oe[7]);
    cov_stop2_cycle: cover property (i_stop2_recovered ##[1:20] ppd_ack);
    cov_analog_gang: cover property (gang_en && i_analog_enable[4] ##1 !o_gang_active[4]);
endmodule // pig_pin_ctrl

// ### verification/pig_pin_env.sv
// pin environment model: external drivers and pull resistors on the interrupt pins
`timescale 1ns/10ps
module pig_pin_env (
    input wire logic i_clk,
    input wire logic [7:0] i_drive_en,
    input wire logic [7:0] i_drive_val,
    input wire logic [7:0] i_pull_enable,
    input wire logic [7:0] i_pull_down,
    output logic [7:0] o_pin
);
    logic tog;
    // a floating pin wanders each cycle so a stale value never passes
    always @(posedge i_clk) begin
        tog <= ~tog;
    end
    initial tog = 1'b0;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (i_drive_en[i]) begin
                o_pin[i] = i_drive_val[i];
            end else if (i_pull_enable[i]) begin
                o_pin[i] = ~i_pull_down[i];
            end else begin
                o_pin[i] = tog ^ i[0];
            end
        end
    end
endmodule // pig_pin_env

// ### verification/testbench.sv
// self-checking bench: apb register traffic, pin interrupts, gang drive, stop modes
`timescale 1ns/10ps
module testbench;
    logic clk, rst_n, psel, penable, pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic pready, pslverr, c0_data, c0_drive, c0_slew, c0_dir, hold, recov;
    logic [7:0] analog, pins, drv_en, drv_val, act, oe, gdata, gdrive, gslew, pull_en, pull_dn;
    logic stop2_sel, irq;
    logic [1:0] port_irq;
    int mismatches, cmp_count, cycles;
    localparam logic [7:0] PA = pig_pkg::ADDR_PORT_BASE;
    localparam logic [7:0] PB = PA + pig_pkg::ADDR_PORT_STRIDE;

    pig_pin_ctrl dut (.i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_port_c_bit0_data(c0_data),
        .i_port_c_bit0_drive_select(c0_drive), .i_port_c_bit0_slew_enable(c0_slew),
        .i_port_c_bit0_direction(c0_dir), .i_analog_enable(analog), .i_stop2_hold(hold),
        .i_stop2_recovered(recov), .i_irq_pin(pins), .o_gang_active(act), .o_gang_oe(oe),
        .o_gang_data(gdata), .o_gang_drive(gdrive), .o_gang_slew(gslew),
        .o_pull_enable(pull_en), .o_pull_down(pull_dn), .o_stop2_select(stop2_sel),
        .o_port_irq(port_irq), .o_irq(irq));
    pig_pin_env env (.i_clk(clk), .i_drive_en(drv_en), .i_drive_val(drv_val),
        .i_pull_enable(pull_en), .i_pull_down(pull_dn), .o_pin(pins));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    //////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            end_of_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // one apb transfer; waits for pready, no wait-state count assumed
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdv = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, a, {24'h000000, d});
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        xfer(1'b0, a, 32'h00000000);
        chk(rdv, {24'h000000, exp});
    endtask
    // masked setup order keeps first enable from raising a false request
    task automatic cfg_port(input logic [7:0] b, input logic [7:0] es, input logic [7:0] pe,
                            input logic [7:0] ps, input logic [7:0] md);
        wr(b + pig_pkg::OFF_SC, md);
        wr(b + pig_pkg::OFF_ES, es);
        wr(b + pig_pkg::OFF_PE, pe);
        wr(b + pig_pkg::OFF_PS, ps);
        wr(b + pig_pkg::OFF_SC, md | 8'h04);
        wr(b + pig_pkg::OFF_SC, md | 8'h02);
    endtask
    //////////////////////////////////////////////////////////////////////////
    initial begin
        {psel, penable, pwrite, hold, recov, c0_dir, c0_slew} = '0;
        {rst_n, paddr, pwdata, analog} = '0;
        {c0_data, c0_drive} = 2'b11;
        drv_en = 8'hfb;
        drv_val = 8'h0f;
        tick(6);
        rst_n <= 1'b1;
        rchk(pig_pkg::ADDR_GANG, 8'h00);
        rchk(pig_pkg::ADDR_PWR, 8'h00);
        rchk(PA + pig_pkg::OFF_SC, 8'h00);
        $display("test reset done");
        // gang: enable plus B2 and B5, second write refused
        wr(pig_pkg::ADDR_GANG, 8'h91);
        wr(pig_pkg::ADDR_GANG, 8'hff);
        rchk(pig_pkg::ADDR_GANG, 8'h91);
        tick(2);
        chk(act, 8'h91);
        chk(oe & 8'h91, 8'h91);
        chk(gdata & 8'h91, 8'h91);
        chk(gdrive & 8'h91, 8'h91);
        chk(gslew & 8'h91, 8'h00);
        analog <= 8'h10;
        tick(2);
        chk(act, 8'h81);
        hold <= 1'b1;
        c0_data <= 1'b0;
        tick(3);
        chk(gdata & 8'h81, 8'h81);
        hold <= 1'b0;
        tick(2);
        chk(gdata & 8'h81, 8'h00);
        $display("test gang done");
        // port a falling edge; pin1 already low at enable, pin2 floats pulled up
        drv_val <= 8'h0d;
        cfg_port(PA, 8'h00, 8'h04, 8'h07, 8'h00);
        chk(pull_en, 8'h04);
        chk(pull_dn, 8'h00);
        tick(3);
        rchk(PA + pig_pkg::OFF_SC, 8'h02);
        drv_val <= 8'h0c;
        tick(1);
        drv_val <= 8'h0d;
        tick(3);
        rchk(PA + pig_pkg::OFF_SC, 8'h0a);
        chk({port_irq, irq}, 3'b011);
        wr(PA + pig_pkg::OFF_SC, 8'h00);
        rchk(PA + pig_pkg::OFF_SC, 8'h08);
        chk(irq, 1'b0);
        wr(PA + pig_pkg::OFF_SC, 8'h06);
        drv_val <= 8'h05;
        tick(3);
        rchk(PA + pig_pkg::OFF_SC, 8'h02);
        $display("test edge port done");
        // port b rising edge and high level on pin b0
        cfg_port(PB, 8'h01, 8'h01, 8'h01, 8'h01);
        chk(pull_dn, 8'h10);
        drv_val <= 8'h1d;
        tick(3);
        rchk(PB + pig_pkg::OFF_SC, 8'h0b);
        chk(port_irq, 2'b10);
        wr(PB + pig_pkg::OFF_SC, 8'h07);
        rchk(PB + pig_pkg::OFF_SC, 8'h0b);
        drv_val <= 8'h0d;
        tick(2);
        wr(PB + pig_pkg::OFF_SC, 8'h07);
        rchk(PB + pig_pkg::OFF_SC, 8'h03);
        $display("test level port done");
        // stop mode select once, then powerdown flag set and acknowledged
        wr(pig_pkg::ADDR_PWR, 8'h01);
        wr(pig_pkg::ADDR_PWR, 8'h00);
        chk(stop2_sel, 1'b1);
        @(posedge clk);
        recov <= 1'b1;
        @(posedge clk);
        recov <= 1'b0;
        wr(pig_pkg::ADDR_PWR, 8'h08);
        rchk(pig_pkg::ADDR_PWR, 8'h09);
        wr(pig_pkg::ADDR_PWR, 8'h04);
        rchk(pig_pkg::ADDR_PWR, 8'h01);
        xfer(1'b0, 8'h40, 32'h00000000);
        chk({31'h00000000, pslverr}, 32'h00000001);
        chk(rdv, 32'h00000000);
        $display("test power and unmapped done");
        end_of_test();
    end
endmodule // testbench
